// ===== cshu_cfg.svh
// register map, reset values and scaling constants of the chroma adjust stage
`ifndef CSHU_CFG_SVH
`define CSHU_CFG_SVH

// address decode width and register byte offsets
`define CSHU_ADDR_W         12
`define CSHU_OFF_CTRL_EVEN  12'h02C
`define CSHU_OFF_CTRL_ODD   12'h0AC
`define CSHU_OFF_U_LOW      12'h034
`define CSHU_OFF_V_LOW      12'h038
`define CSHU_OFF_HUE        12'h03C
`define CSHU_OFF_STATUS     12'h0B0

// reset values
`define CSHU_RST_CTRL       8'h20
`define CSHU_RST_U_LOW      8'hFE
`define CSHU_RST_V_LOW      8'hB4
`define CSHU_RST_HUE        8'h00

// control register field positions
`define CSHU_BIT_U_TOP      1
`define CSHU_BIT_V_TOP      0

// status register field positions
`define CSHU_BIT_ST_FIELD   0
`define CSHU_BIT_ST_U_CLIP  1
`define CSHU_BIT_ST_V_CLIP  2

// gain scaling: out = in * gain * recip / 2**shift
`define CSHU_GAIN_W         9
`define CSHU_RECIP_W        10
`define CSHU_RECIP_SHIFT    16
`define CSHU_RECIP_U        10'h102
`define CSHU_RECIP_V        10'h16C
`define CSHU_U_UNITY        9'h0FE
`define CSHU_V_UNITY        9'h0B4
`define CSHU_GAIN_ZERO      9'h000

// hue: 512 steps per turn, one step per code
`define CSHU_HUE_W          8
`define CSHU_HUE_TURN_LOG2  9
`define CSHU_HUE_NEG_QUART  8'h80

`endif

// ===== cshu_pkg.sv
// types shared by the chroma saturation and hue adjust stage
`default_nettype none
package cshu_pkg;

    // ahb data phase kind, one-hot
    typedef enum logic [2:0] {
        DP_NONE  = 3'b001,
        DP_WRITE = 3'b010,
        DP_READ  = 3'b100
    } cshu_dphase_t;

    // register select, one-hot
    typedef enum logic [6:0] {
        SEL_NONE   = 7'b000_0001,
        SEL_CTRL_E = 7'b000_0010,
        SEL_CTRL_O = 7'b000_0100,
        SEL_U_LOW  = 7'b000_1000,
        SEL_V_LOW  = 7'b001_0000,
        SEL_HUE    = 7'b010_0000,
        SEL_STATUS = 7'b100_0000
    } cshu_sel_t;

endpackage : cshu_pkg
`default_nettype wire

// ===== cshu_chroma_adj.sv
// chroma saturation gain and hue phase offset with ahb-lite registers
// How it works
// - u gain low byte resets to 0xFE, unity with top bit clear
// - u gain is nine bits: control top bit over the low byte
// - u output is input times gain over 254, zero gain gives zero
// - v gain low byte resets to 0xB4, unity with top bit clear
// - v gain is nine bits: control top bit over the low byte
// - v output is input times gain over 180, zero gain gives zero
// - signed hue byte is added to the demodulating subcarrier phase
// - hue register resets to zero, no phase offset
// - hue has 256 steps of about 0.7 degrees, 0x80 is minus 90
// - u gain top bit is control bit 1, reset zero
// - v gain top bit is control bit 0, reset zero
// - even and odd control registers, chosen by current field
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cshu_cfg.svh"

module cshu_chroma_adj #(
    parameter int CW = 8,
    parameter int PW = 16
) (
    // clock and reset
    input  wire logic                 REF_CLK_I,
    input  wire logic                 ARST_N_I,
    // ahb-lite slave
    input  wire logic                 HSEL_I,
    input  wire logic [31:0]          HADDR_I,
    input  wire logic [1:0]           HTRANS_I,
    input  wire logic                 HWRITE_I,
    input  wire logic [2:0]           HSIZE_I,
    input  wire logic [31:0]          HWDATA_I,
    input  wire logic                 HREADY_I,
    output logic      [31:0]          HRDATA_O,
    output logic                      HREADYOUT_O,
    output logic                      HRESP_O,
    // chroma stream in
    input  wire logic                 CHROMA_VALID_I,
    input  wire logic signed [CW-1:0] U_I,
    input  wire logic signed [CW-1:0] V_I,
    input  wire logic                 FIELD_ODD_I,
    input  wire logic [PW-1:0]        PHASE_I,
    // chroma stream out
    output logic                      CHROMA_VALID_O,
    output logic signed [CW-1:0]      U_O,
    output logic signed [CW-1:0]      V_O,
    output logic [PW-1:0]             PHASE_O
);

    localparam int PROD_W = CW + `CSHU_GAIN_W + `CSHU_RECIP_W + 2;
    if (CW < 2 || CW > 16 || PW < `CSHU_HUE_TURN_LOG2)
    begin : g_bad_par
        $error("CW must lie in 2..16 and PW must hold the hue steps");
    end

    function automatic cshu_pkg::cshu_sel_t cshu_decode(input logic [31:0] addr);
        logic [`CSHU_ADDR_W-1:0] a;
        a = addr[`CSHU_ADDR_W-1:0];
        if (a == `CSHU_OFF_CTRL_EVEN)
            cshu_decode = cshu_pkg::SEL_CTRL_E;
        else if (a == `CSHU_OFF_CTRL_ODD)
            cshu_decode = cshu_pkg::SEL_CTRL_O;
        else if (a == `CSHU_OFF_U_LOW)
            cshu_decode = cshu_pkg::SEL_U_LOW;
        else if (a == `CSHU_OFF_V_LOW)
            cshu_decode = cshu_pkg::SEL_V_LOW;
        else if (a == `CSHU_OFF_HUE)
            cshu_decode = cshu_pkg::SEL_HUE;
        else if (a == `CSHU_OFF_STATUS)
            cshu_decode = cshu_pkg::SEL_STATUS;
        else
            cshu_decode = cshu_pkg::SEL_NONE;
    endfunction : cshu_decode

    // register state
    cshu_pkg::cshu_dphase_t   dphase, next_dphase;
    cshu_pkg::cshu_sel_t      dsel, next_dsel;
    logic [7:0]               ctrl_even, next_ctrl_even;
    logic [7:0]               ctrl_odd, next_ctrl_odd;
    logic [7:0]               u_gain_low_byte, next_u_gain_low_byte;
    logic [7:0]               v_gain_low_byte, next_v_gain_low_byte;
    logic [7:0]               hue_phase_offset, next_hue_phase_offset;
    logic                     u_clip_seen, next_u_clip_seen;
    logic                     v_clip_seen, next_v_clip_seen;
    logic [31:0]              rdata, next_rdata;
    // stream state
    logic                     valid_q, next_valid_q;
    logic signed [CW-1:0]     u_q, next_u_q;
    logic signed [CW-1:0]     v_q, next_v_q;
    logic [PW-1:0]            phase_q, next_phase_q;
    // datapath
    logic [7:0]               ctrl_cur;
    logic [`CSHU_GAIN_W-1:0]  u_gain_full, v_gain_full;
    logic [`CSHU_GAIN_W-1:0]  gain_full  [2];
    logic [`CSHU_RECIP_W-1:0] recip      [2];
    logic signed [CW-1:0]     chroma_in  [2];
    logic signed [CW-1:0]     scaled     [2];
    logic                     clipped    [2];
    logic [PW-1:0]            hue_step;
    logic                     addr_take, wr_now;

    assign ctrl_cur = FIELD_ODD_I ? ctrl_odd : ctrl_even;
    assign u_gain_full = {ctrl_cur[`CSHU_BIT_U_TOP], u_gain_low_byte};
    assign v_gain_full = {ctrl_cur[`CSHU_BIT_V_TOP], v_gain_low_byte};
    assign gain_full = '{u_gain_full, v_gain_full};
    assign recip     = '{`CSHU_RECIP_U, `CSHU_RECIP_V};
    assign chroma_in = '{U_I, V_I};

    // reciprocal multiply avoids a divider; near the true quotient, exact at unity gain for 8-bit chroma
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        localparam logic signed [PROD_W-1:0] CMAX = PROD_W'((1 << (CW - 1)) - 1);
        localparam logic signed [PROD_W-1:0] CMIN = PROD_W'(-(1 << (CW - 1)));
        localparam logic signed [PROD_W-1:0] HALF = PROD_W'(1 << (`CSHU_RECIP_SHIFT - 1));
        logic signed [PROD_W-1:0] prod;
        logic signed [PROD_W-1:0] rnd;
        logic                     hi;
        logic                     lo;
        assign prod = PROD_W'(chroma_in[c])
                      * PROD_W'($signed({1'b0, gain_full[c]}))
                      * PROD_W'($signed({1'b0, recip[c]}));
        assign rnd = (prod + HALF) >>> `CSHU_RECIP_SHIFT;
        assign hi = rnd > CMAX;
        assign lo = rnd < CMIN;
        assign scaled[c]  = hi ? CMAX[CW-1:0] : (lo ? CMIN[CW-1:0] : rnd[CW-1:0]);
        assign clipped[c] = hi | lo;
    end

    // signed hue, 512 steps per turn
    assign hue_step = PW'({{(PW - `CSHU_HUE_W){hue_phase_offset[`CSHU_HUE_W-1]}},
                          hue_phase_offset}) << (PW - `CSHU_HUE_TURN_LOG2);
    assign addr_take = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign wr_now    = (dphase == cshu_pkg::DP_WRITE);

    always_comb
    begin
        next_dphase           = cshu_pkg::DP_NONE;
        next_dsel             = cshu_pkg::SEL_NONE;
        next_ctrl_even        = ctrl_even;
        next_ctrl_odd         = ctrl_odd;
        next_u_gain_low_byte  = u_gain_low_byte;
        next_v_gain_low_byte  = v_gain_low_byte;
        next_hue_phase_offset = hue_phase_offset;
        next_u_clip_seen      = u_clip_seen;
        next_v_clip_seen      = v_clip_seen;
        next_rdata            = rdata;
        if (addr_take)
        begin
            next_dphase = HWRITE_I ? cshu_pkg::DP_WRITE : cshu_pkg::DP_READ;
            next_dsel   = cshu_decode(HADDR_I);
        end
        if (wr_now)
        begin
            case (dsel)
                cshu_pkg::SEL_CTRL_E: next_ctrl_even = HWDATA_I[7:0];
                cshu_pkg::SEL_CTRL_O: next_ctrl_odd = HWDATA_I[7:0];
                cshu_pkg::SEL_U_LOW:  next_u_gain_low_byte = HWDATA_I[7:0];
                cshu_pkg::SEL_V_LOW:  next_v_gain_low_byte = HWDATA_I[7:0];
                cshu_pkg::SEL_HUE:    next_hue_phase_offset = HWDATA_I[7:0];
                cshu_pkg::SEL_STATUS:
                begin
                    next_u_clip_seen = u_clip_seen & ~HWDATA_I[`CSHU_BIT_ST_U_CLIP];
                    next_v_clip_seen = v_clip_seen & ~HWDATA_I[`CSHU_BIT_ST_V_CLIP];
                end
                default: ;
            endcase
        end
        // new clip after the clear so an event in the clear cycle survives
        if (CHROMA_VALID_I && clipped[0])
            next_u_clip_seen = 1'b1;
        if (CHROMA_VALID_I && clipped[1])
            next_v_clip_seen = 1'b1;
        // read data from next values so a write just before is seen
        if (addr_take && !HWRITE_I)
        begin
            next_rdata = 32'h0000_0000;
            case (cshu_decode(HADDR_I))
                cshu_pkg::SEL_CTRL_E: next_rdata[7:0] = next_ctrl_even;
                cshu_pkg::SEL_CTRL_O: next_rdata[7:0] = next_ctrl_odd;
                cshu_pkg::SEL_U_LOW:  next_rdata[7:0] = next_u_gain_low_byte;
                cshu_pkg::SEL_V_LOW:  next_rdata[7:0] = next_v_gain_low_byte;
                cshu_pkg::SEL_HUE:    next_rdata[7:0] = next_hue_phase_offset;
                cshu_pkg::SEL_STATUS:
                begin
                    next_rdata[`CSHU_BIT_ST_FIELD]  = FIELD_ODD_I;
                    next_rdata[`CSHU_BIT_ST_U_CLIP] = next_u_clip_seen;
                    next_rdata[`CSHU_BIT_ST_V_CLIP] = next_v_clip_seen;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            dphase           <= cshu_pkg::DP_NONE;
            dsel             <= cshu_pkg::SEL_NONE;
            ctrl_even        <= `CSHU_RST_CTRL;
            ctrl_odd         <= `CSHU_RST_CTRL;
            u_gain_low_byte  <= `CSHU_RST_U_LOW;
            v_gain_low_byte  <= `CSHU_RST_V_LOW;
            hue_phase_offset <= `CSHU_RST_HUE;
            u_clip_seen      <= 1'b0;
            v_clip_seen      <= 1'b0;
            rdata            <= 32'h0000_0000;
        end
        else
        begin
            dphase           <= next_dphase;
            dsel             <= next_dsel;
            ctrl_even        <= next_ctrl_even;
            ctrl_odd         <= next_ctrl_odd;
            u_gain_low_byte  <= next_u_gain_low_byte;
            v_gain_low_byte  <= next_v_gain_low_byte;
            hue_phase_offset <= next_hue_phase_offset;
            u_clip_seen      <= next_u_clip_seen;
            v_clip_seen      <= next_v_clip_seen;
            rdata            <= next_rdata;
        end
    end

    always_comb
    begin
        next_valid_q = CHROMA_VALID_I;
        next_u_q     = CHROMA_VALID_I ? scaled[0] : u_q;
        next_v_q     = CHROMA_VALID_I ? scaled[1] : v_q;
        next_phase_q = PHASE_I + hue_step;
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            valid_q <= 1'b0;
            u_q     <= '0;
            v_q     <= '0;
            phase_q <= '0;
        end
        else
        begin
            valid_q <= next_valid_q;
            u_q     <= next_u_q;
            v_q     <= next_v_q;
            phase_q <= next_phase_q;
        end
    end

    // zero-wait slave, always okay
    assign HREADYOUT_O    = 1'b1;
    assign HRESP_O        = 1'b0;
    assign HRDATA_O       = rdata;
    assign CHROMA_VALID_O = valid_q;
    assign U_O            = u_q;
    assign V_O            = v_q;
    assign PHASE_O        = phase_q;

    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    logic first_q;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            first_q <= 1'b0;
        else
            first_q <= 1'b1;
    end

    sequence s_wr_addr(logic [`CSHU_ADDR_W-1:0] off);
        HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I
            && (HADDR_I[`CSHU_ADDR_W-1:0] == off);
    endsequence
    sequence s_data_phase;
        HREADY_I;
    endsequence
    a_reset_defaults: assert property (
        !first_q |-> (u_gain_low_byte == `CSHU_RST_U_LOW)
                     && (v_gain_low_byte == `CSHU_RST_V_LOW)
                     && (hue_phase_offset == `CSHU_RST_HUE)
                     && (ctrl_even == `CSHU_RST_CTRL) && (ctrl_odd == `CSHU_RST_CTRL))
        else $error("register defaults wrong after reset");
    a_u_write_lands: assert property (
        s_wr_addr(`CSHU_OFF_U_LOW) ##1 s_data_phase
            |=> u_gain_low_byte == $past(HWDATA_I[7:0]))
        else $error("u gain low byte write lost");
    // first_q: the output flops load nothing at the releasing edge
    a_u_unity_pass: assert property (
        first_q && CHROMA_VALID_I && (u_gain_full == `CSHU_U_UNITY) |=> U_O == $past(U_I))
        else $error("u unity gain not transparent");
    a_v_unity_pass: assert property (
        first_q && CHROMA_VALID_I && (v_gain_full == `CSHU_V_UNITY) |=> V_O == $past(V_I))
        else $error("v unity gain not transparent");
    a_zero_gain_mute: assert property (
        first_q && CHROMA_VALID_I && (u_gain_full == `CSHU_GAIN_ZERO) |=> U_O == '0)
        else $error("zero u gain not muting chroma");
    a_v_zero_mute: assert property (
        first_q && CHROMA_VALID_I && (v_gain_full == `CSHU_GAIN_ZERO) |=> V_O == '0)
        else $error("zero v gain not muting chroma");
    a_no_wrap_up: assert property (
        first_q && CHROMA_VALID_I && (u_gain_full >= `CSHU_U_UNITY) && (U_I > 0)
            |=> (U_O >= $past(U_I)) && CHROMA_VALID_O)
        else $error("u gain above unity wrapped");
    a_field_top_bit: assert property (
        FIELD_ODD_I |-> (u_gain_full[`CSHU_GAIN_W-1] == ctrl_odd[`CSHU_BIT_U_TOP])
                       && (v_gain_full[`CSHU_GAIN_W-1] == ctrl_odd[`CSHU_BIT_V_TOP]))
        else $error("odd field top bits not used");
    a_hue_zero_pass: assert property (
        first_q && (hue_phase_offset == `CSHU_RST_HUE) |=> PHASE_O == $past(PHASE_I))
        else $error("zero hue moved the phase");
    a_hue_quarter: assert property (
        first_q && (hue_phase_offset == `CSHU_HUE_NEG_QUART)
            |=> PW'(PHASE_O - $past(PHASE_I)) == PW'(3 << (PW - 2)))
        else $error("hue 0x80 not minus a quarter turn");
    a_hue_follows: assert property (
        s_wr_addr(`CSHU_OFF_HUE) ##1 s_data_phase ##1 1'b1
            |=> PHASE_O == PW'($past(PHASE_I)
                + (PW'({{(PW - `CSHU_HUE_W){$past(HWDATA_I[7], 2)}}, $past(HWDATA_I[7:0], 2)})
                   << (PW - `CSHU_HUE_TURN_LOG2))))
        else $error("written hue not added to phase");

endmodule : cshu_chroma_adj
`default_nettype wire

// ===== tb.sv
// self-checking bench for the chroma saturation and hue adjust stage
`timescale 1ns/1ps
`default_nettype none
`include "cshu_cfg.svh"

module tb;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              hsel = 1'b0;
    logic [31:0]       haddr = 32'h0;
    logic [1:0]        htrans = 2'b00;
    logic              hwrite = 1'b0;
    logic [31:0]       hwdata = 32'h0;
    logic              cv_in = 1'b0;
    logic [7:0]        u_in = 8'h00;
    logic [7:0]        v_in = 8'h00;
    logic              odd = 1'b0;
    logic [15:0]       ph_in = 16'h0000;
    wire logic [31:0]  hrdata;
    wire logic         hready;
    wire logic         hresp;
    wire logic         cv_out;
    wire logic [7:0]   u_out;
    wire logic [7:0]   v_out;
    wire logic [15:0]  ph_out;
    logic [7:0]        sh_ce, sh_co, sh_u, sh_v, sh_h;
    logic [7:0]        q_u[$];
    logic [7:0]        q_v[$];
    logic [15:0]       q_p[$];
    logic [31:0]       rd;
    int                failures = 0;
    int                n_compared = 0;
    int                gl[7] = '{0, 1, 128, 180, 254, 255, 511};
    int                hl[5] = '{8'h80, 8'h7F, 8'hFF, 8'h01, 8'h00};

    cshu_chroma_adj #(.CW(8), .PW(16)) cshu_chroma_adj_i (
        .REF_CLK_I(clk), .ARST_N_I(arst_n),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .CHROMA_VALID_I(cv_in), .U_I(u_in), .V_I(v_in), .FIELD_ODD_I(odd),
        .PHASE_I(ph_in), .CHROMA_VALID_O(cv_out), .U_O(u_out), .V_O(v_out),
        .PHASE_O(ph_out)
    );

    always #5 clk = ~clk;

    task automatic conclude;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                failures++;
                conclude();
            end
            @(posedge clk);
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        hsel <= 1'b0;
    endtask : ahb

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        ahb(1'b1, a, {24'h0, d});
        case (a)
            `CSHU_OFF_CTRL_EVEN: sh_ce = d;
            `CSHU_OFF_CTRL_ODD:  sh_co = d;
            `CSHU_OFF_U_LOW:     sh_u = d;
            `CSHU_OFF_V_LOW:     sh_v = d;
            `CSHU_OFF_HUE:       sh_h = d;
            default:             ;
        endcase
    endtask : reg_wr

    task automatic check_rst;
        ahb(1'b0, `CSHU_OFF_CTRL_EVEN, 32'h0);
        check(rd, 32'h20);
        ahb(1'b0, `CSHU_OFF_CTRL_ODD, 32'h0);
        check(rd, 32'h20);
        ahb(1'b0, `CSHU_OFF_U_LOW, 32'h0);
        check(rd, 32'hFE);
        ahb(1'b0, `CSHU_OFF_V_LOW, 32'h0);
        check(rd, 32'hB4);
        ahb(1'b0, `CSHU_OFF_HUE, 32'h0);
        check(rd, 32'h00);
        {sh_ce, sh_co, sh_u, sh_v, sh_h} = {8'h20, 8'h20, 8'hFE, 8'hB4, 8'h00};
    endtask : check_rst

    // rounded product, saturated rather than wrapped
    function automatic logic [7:0] scale(input logic signed [7:0] x, input int g, input int r);
        longint p;
        p = (longint'(x) * g * r + 32768) >>> 16;
        if (p > 127)
            p = 127;
        if (p < -128)
            p = -128;
        return p[7:0];
    endfunction : scale

    task automatic send(input logic [7:0] xu, input logic [7:0] xv, input logic f,
                        input logic [15:0] ph);
        logic [7:0] c;
        c = f ? sh_co : sh_ce;
        @(posedge clk);
        cv_in <= 1'b1;
        u_in <= xu;
        v_in <= xv;
        odd <= f;
        ph_in <= ph;
        q_u.push_back(scale(xu, int'({c[1], sh_u}), 258));
        q_v.push_back(scale(xv, int'({c[0], sh_v}), 364));
        q_p.push_back(ph + ({{8{sh_h[7]}}, sh_h} << 7));
    endtask : send

    task automatic idle;
        @(posedge clk);
        cv_in <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : idle

    // outputs are settled by the falling edge
    always @(negedge clk)
    begin
        if (arst_n === 1'b1 && cv_out === 1'b1)
        begin
            if (q_u.size() == 0)
            begin
                failures++;
                $display("BAD %0t sample with nothing expected", $time);
            end
            else
            begin
                check({24'h0, u_out}, {24'h0, q_u.pop_front()});
                check({24'h0, v_out}, {24'h0, q_v.pop_front()});
                check({16'h0, ph_out}, {16'h0, q_p.pop_front()});
            end
        end
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        failures++;
        conclude();
    end

    initial
    begin
        void'($urandom(50));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        check_rst();
        // unity defaults pass chroma and phase unchanged
        for (int i = 0; i < 16; i++)
            send(8'($urandom), 8'($urandom), i[0], 16'($urandom));
        idle();
        // gain codes at the corners, with full-scale inputs
        for (int i = 0; i < 7; i++)
        begin
            reg_wr(`CSHU_OFF_CTRL_EVEN, 8'(8'h20 | (gl[i] >> 7 & 2) | (gl[6-i] >> 8)));
            reg_wr(`CSHU_OFF_CTRL_ODD, sh_ce);
            reg_wr(`CSHU_OFF_U_LOW, 8'(gl[i]));
            reg_wr(`CSHU_OFF_V_LOW, 8'(gl[6-i]));
            ahb(1'b0, `CSHU_OFF_U_LOW, 32'h0);
            check(rd, 32'(gl[i] & 255));
            send(8'h7F, 8'h80, 1'b0, 16'($urandom));
            send(8'h80, 8'h7F, 1'b1, 16'($urandom));
            send(8'($urandom), 8'($urandom), 1'b0, 16'($urandom));
            idle();
        end
        // clip flags stick until written clear
        ahb(1'b0, `CSHU_OFF_STATUS, 32'h0);
        check(rd, 32'h6);
        ahb(1'b1, `CSHU_OFF_STATUS, 32'h6);
        ahb(1'b0, `CSHU_OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        // even and odd top bits differ, field picks one
        reg_wr(`CSHU_OFF_CTRL_EVEN, 8'h22);
        reg_wr(`CSHU_OFF_CTRL_ODD, 8'h21);
        reg_wr(`CSHU_OFF_U_LOW, 8'h80);
        reg_wr(`CSHU_OFF_V_LOW, 8'h80);
        for (int i = 0; i < 8; i++)
            send(8'($urandom), 8'($urandom), i[0], 16'($urandom));
        idle();
        // signed hue codes shift the phase word
        for (int i = 0; i < 5; i++)
        begin
            reg_wr(`CSHU_OFF_HUE, 8'(hl[i]));
            ahb(1'b0, `CSHU_OFF_HUE, 32'h0);
            check(rd, 32'(hl[i]));
            send(8'($urandom), 8'($urandom), 1'b0, 16'($urandom));
            send(8'($urandom), 8'($urandom), 1'b1, 16'hFFFF);
            idle();
        end
        // unmapped place reads zero after a write to it
        ahb(1'b1, 12'h100, 32'hFF);
        ahb(1'b0, 12'h100, 32'h0);
        check(rd, 32'h0);
        // second reset in mid-run restores defaults
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        check_rst();
        send(8'h81, 8'h7F, 1'b1, 16'h1234);
        idle();
        // equal code steps on both gains, a larger relative cut on v than on u
        reg_wr(`CSHU_OFF_U_LOW, sh_u - 8'h40);
        reg_wr(`CSHU_OFF_V_LOW, sh_v - 8'h40);
        send(8'($urandom), 8'($urandom), 1'b0, 16'($urandom));
        idle();
        check(q_u.size(), 0);
        conclude();
    end
endmodule : tb
`default_nettype wire
